/* rtl/dcbf_fifo.sv */
// Dual clock byte FIFO core with pin-side push and pop ports and AXI4-Lite status.
// Assumes push and pop clocks run slower than a third of core_clk, with pin data
// and enables stable for three core cycles around each rising edge.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns

// Contract
// RULE1 - Byte words, depth 64 to 4096 entries
// RULE2 - Eight-bit push port and pop port
// RULE3 - Push clock edge with enable low stores
// RULE4 - Full flag low ignores pushes
// RULE5 - Pop clock edge with enable low presents oldest
// RULE6 - Empty flag low ignores pops
// RULE7 - Output enable high floats pop bus
// RULE8 - Clear zeroes pointers, sets flag values
// RULE9 - Writer pulses clear before first push
// RULE10 - Empty flag low when nothing stored
// RULE11 - Almost-empty low at seven or fewer
// RULE12 - Almost-full low at full minus seven
// RULE13 - Full flag low when all occupied
// RULE14 - Works with tied or independent clocks
// RULE15 - Crossing signals pass two-flop synchronisers
// RULE16 - Almost flags use seven-word margins
module dcbf_fifo
   import dcbf_pkg::*;
#(
   parameter int DEPTH = dcbf_pkg::DEPTH_DEF
) (
   // Core clock and reset
   input  wire logic                              core_clk,
   input  wire logic                              rst_n,
   // AXI4-Lite write channels
   input  wire logic [dcbf_pkg::AXI_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output wire logic                              s_axi_awready,
   input  wire logic [31:0]                       s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output wire logic                              s_axi_wready,
   output wire logic [1:0]                        s_axi_bresp,
   output wire logic                              s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [dcbf_pkg::AXI_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output wire logic                              s_axi_arready,
   output wire logic [31:0]                       s_axi_rdata,
   output wire logic [1:0]                        s_axi_rresp,
   output wire logic                              s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   // Push port pins
   input  wire logic                              push_clk,
   input  wire logic                              push_en_n,
   input  wire logic [dcbf_pkg::WORD_W-1:0]       push_word,
   // Pop port pins
   input  wire logic                              pop_clk,
   input  wire logic                              pop_en_n,
   input  wire logic                              out_en_n,
   output wire logic [dcbf_pkg::WORD_W-1:0]       pop_word,
   output wire logic                              pop_word_oe,
   // Clear and flags
   input  wire logic                              fifo_clear_n,
   output wire logic                              empty_flag_n,
   output wire logic                              almost_empty_n,
   output wire logic                              near_full_n,
   output wire logic                              full_flag_n
);
   import dcbf_pkg::*;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int AW    = $clog2(DEPTH);
   localparam int CW    = AW + 1;
   localparam int PIN_W = 6 + WORD_W;
   localparam logic [CW-1:0] DEPTH_C  = CW'(DEPTH);
   localparam logic [CW-1:0] MARGIN_C = CW'(ALMOST_OFFSET);

   if (!(DEPTH == 64 || DEPTH == 256 || DEPTH == 512 || DEPTH == 1024 ||
         DEPTH == 2048 || DEPTH == 4096)) begin : g_bad_depth
      $error("DEPTH must be 64, 256, 512, 1024, 2048 or 4096");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0]  pinMeta_r;
   logic [PIN_W-1:0]  pinSync_r;
   logic              pushClkPrev_r;
   logic              popClkPrev_r;
   logic              pushClkS;
   logic              pushEnNS;
   logic              popClkS;
   logic              popEnNS;
   logic              outEnNS;
   logic              clearNS;
   logic [WORD_W-1:0] pushWordS;

   // Every pin, clocks included, is only seen after two flops
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pinMeta_r <= '0;
         pinSync_r <= '0;
      end else begin
         pinMeta_r <= {push_clk, push_en_n, pop_clk, pop_en_n, out_en_n,
                       fifo_clear_n, push_word}; // RULE15
         pinSync_r <= pinMeta_r; // RULE15
      end
   end

   assign {pushClkS, pushEnNS, popClkS, popEnNS, outEnNS, clearNS, pushWordS} = pinSync_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pushClkPrev_r <= 1'h0;
         popClkPrev_r  <= 1'h0;
      end else begin
         pushClkPrev_r <= pushClkS;
         popClkPrev_r  <= popClkS;
      end
   end

   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   logic              ctrlClear_r;
   logic              clearing;
   logic              pushEdge;
   logic              popEdge;
   logic              pushReq;
   logic              popReq;
   logic              pushOk;
   logic              popOk;
   logic              emptyN_r;
   logic              almostEmptyN_r;
   logic              nearFullN_r;
   logic              fullN_r;
   logic [CW-1:0]     cnt_r;
   logic [CW-1:0]     cnt_nxt;

   // Each clock edge is seen as a one-cycle event, so tied or free clocks act alike
   assign pushEdge = pushClkS && !pushClkPrev_r; // RULE14
   assign popEdge  = popClkS && !popClkPrev_r; // RULE14
   assign clearing = !clearNS || ctrlClear_r;
   assign pushReq  = pushEdge && !pushEnNS && !clearing;
   assign popReq   = popEdge && !popEnNS && !clearing;

   // ---------------------------------------------------------------
   // Storage and pointers
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] mem [DEPTH];
   logic [CW-1:0]     wrPtr_r;
   logic [CW-1:0]     fetchPtr_r;
   logic [WORD_W-1:0] popWord_r;

   dcbf_stream_if #(.W(WORD_W)) fetchIf ();
   dcbf_stream_if #(.W(WORD_W)) headIf ();

   assign pushOk = pushReq && fullN_r; // RULE4
   assign popOk  = popReq && emptyN_r && headIf.valid; // RULE6

   always_ff @(posedge core_clk) begin
      if (pushOk) begin
         mem[wrPtr_r[AW-1:0]] <= pushWordS; // RULE3
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || clearing) begin
         wrPtr_r <= '0; // RULE8
      end else if (pushOk) begin
         wrPtr_r <= wrPtr_r + CW'(1); // RULE3
      end
   end

   // Prefetch keeps the oldest word waiting, so a pop needs no array read
   assign fetchIf.valid = (fetchPtr_r != wrPtr_r);
   assign fetchIf.data  = mem[fetchPtr_r[AW-1:0]];

   always_ff @(posedge core_clk) begin
      if (!rst_n || clearing) begin
         fetchPtr_r <= '0; // RULE8
      end else if (fetchIf.valid && fetchIf.ready) begin
         fetchPtr_r <= fetchPtr_r + CW'(1);
      end
   end

   dcbf_pop_buffer #(.W(WORD_W)) u_pop_buffer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .flush    (clearing),
      .fill     (fetchIf.snk),
      .drain    (headIf.src)
   );

   assign headIf.ready = popOk;

   always_ff @(posedge core_clk) begin
      if (!rst_n || clearing) begin
         popWord_r <= '0;
      end else if (popOk) begin
         popWord_r <= headIf.data; // RULE5
      end
   end

   assign pop_word    = popWord_r; // RULE2
   assign pop_word_oe = !outEnNS; // RULE7

   // ---------------------------------------------------------------
   // Count and flags
   // ---------------------------------------------------------------
   assign cnt_nxt = cnt_r + CW'(pushOk) - CW'(popOk);

   always_ff @(posedge core_clk) begin
      if (!rst_n || clearing) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt; // RULE1
      end
   end

   // Read-side flags move on pop edges only: a fresh push shows at the next one
   always_ff @(posedge core_clk) begin
      if (!rst_n || clearing) begin
         emptyN_r       <= 1'h0; // RULE8
         almostEmptyN_r <= 1'h0; // RULE8
      end else if (popEdge) begin
         emptyN_r       <= (cnt_nxt != '0); // RULE10
         almostEmptyN_r <= (cnt_nxt > MARGIN_C); // RULE11 RULE16
      end
   end

   // Write-side flags move on push edges only, so they are pessimistic after pops
   always_ff @(posedge core_clk) begin
      if (!rst_n || clearing) begin
         fullN_r     <= 1'h1; // RULE8
         nearFullN_r <= 1'h1; // RULE8
      end else if (pushEdge) begin
         fullN_r     <= (cnt_nxt != DEPTH_C); // RULE13
         nearFullN_r <= ((DEPTH_C - cnt_nxt) > MARGIN_C); // RULE12 RULE16
      end
   end

   assign empty_flag_n   = emptyN_r;
   assign almost_empty_n = almostEmptyN_r;
   assign near_full_n    = nearFullN_r;
   assign full_flag_n    = fullN_r;

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic                  awHave_r;
   logic                  wHave_r;
   logic [AXI_ADDR_W-1:0] awAddr_r;
   logic [31:0]           wData_r;
   logic [3:0]            wStrb_r;
   logic                  bValid_r;
   logic [1:0]            bResp_r;
   logic                  rValid_r;
   logic [1:0]            rResp_r;
   logic [31:0]           rData_r;
   logic                  doWrite;

   function automatic logic [3:0] wordAddr(input logic [AXI_ADDR_W-1:0] a);
      return {a[3:2], 2'h0};
   endfunction : wordAddr

   assign s_axi_awready = !awHave_r && !bValid_r;
   assign s_axi_wready  = !wHave_r && !bValid_r;
   assign s_axi_arready = !rValid_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rresp   = rResp_r;
   assign s_axi_rdata   = rData_r;
   assign doWrite       = awHave_r && wHave_r && !bValid_r;

   // Address and data may arrive in either order; each is parked until both are in
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         awHave_r <= 1'h0;
         wHave_r  <= 1'h0;
         awAddr_r <= '0;
         wData_r  <= '0;
         wStrb_r  <= '0;
      end else if (doWrite) begin
         awHave_r <= 1'h0;
         wHave_r  <= 1'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_r <= 1'h1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_r <= 1'h1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bValid_r    <= 1'h0;
         bResp_r     <= RESP_OKAY;
         ctrlClear_r <= CTRL_CLEAR_RST;
      end else if (doWrite) begin
         bValid_r <= 1'h1;
         unique case (wordAddr(awAddr_r))
            ADDR_CTRL: begin
               bResp_r <= RESP_OKAY;
               if (wStrb_r[0]) begin
                  ctrlClear_r <= wData_r[CTRL_CLEAR_POS];
               end
            end
            ADDR_STATUS, ADDR_DEPTH: begin
               bResp_r <= RESP_OKAY;
            end
            default: begin
               bResp_r <= RESP_SLVERR;
            end
         endcase
      end else if (bValid_r && s_axi_bready) begin
         bValid_r <= 1'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rValid_r <= 1'h0;
         rResp_r  <= RESP_OKAY;
         rData_r  <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_r <= 1'h1;
         rResp_r  <= RESP_OKAY;
         rData_r  <= '0;
         unique case (wordAddr(s_axi_araddr))
            ADDR_CTRL: begin
               rData_r[CTRL_CLEAR_POS] <= ctrlClear_r;
            end
            ADDR_STATUS: begin
               rData_r[ST_EMPTY_POS]  <= emptyN_r;
               rData_r[ST_AEMPTY_POS] <= almostEmptyN_r;
               rData_r[ST_NFULL_POS]  <= nearFullN_r;
               rData_r[ST_FULL_POS]   <= fullN_r;
               rData_r[ST_COUNT_POS +: CW] <= cnt_r;
            end
            ADDR_DEPTH: begin
               rData_r <= 32'(DEPTH);
            end
            default: begin
               rResp_r <= RESP_SLVERR;
            end
         endcase
      end else if (rValid_r && s_axi_rready) begin
         rValid_r <= 1'h0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_count_bound : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
      cnt_r <= DEPTH_C) else $error("stored count above depth");

   a_push_advance : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
      pushReq && fullN_r |=> (wrPtr_r - $past(wrPtr_r)) == CW'(1))
      else $error("accepted push did not advance write pointer");

   a_push_full_hold : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
      pushReq && !fullN_r |=> $stable(wrPtr_r) && cnt_r == $past(cnt_r) - CW'($past(popOk)))
      else $error("push taken while full flag low");

   a_pop_presents : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
      popOk |=> pop_word == $past(headIf.data))
      else $error("pop did not present oldest word");

   a_pop_empty_hold : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
      popReq && !emptyN_r |=> $stable(pop_word) && cnt_r == $past(cnt_r) + CW'($past(pushOk)))
      else $error("pop taken while empty flag low");

   a_out_float : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
      out_en_n [*4] |-> !pop_word_oe) else $error("pop bus driven while disabled");

   a_clear_flags : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE8
      clearing |=> !empty_flag_n && !almost_empty_n && full_flag_n && near_full_n
                   && cnt_r == '0) else $error("clear left flags or count wrong");

   a_empty_on_pop : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE10
      $rose(empty_flag_n) |-> $past(popEdge) && $past(cnt_nxt) != '0)
      else $error("empty flag rose off a pop edge");

   a_aempty_level : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
      popEdge && !clearing |=> almost_empty_n == ($past(cnt_nxt) > MARGIN_C))
      else $error("almost-empty flag wrong after pop edge");

   a_nfull_level : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
      pushEdge && !clearing |=> near_full_n == ((DEPTH_C - $past(cnt_nxt)) > MARGIN_C))
      else $error("almost-full flag wrong after push edge");

   a_full_on_push : assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
      $fell(full_flag_n) |-> $past(pushEdge) && $past(cnt_nxt) == DEPTH_C)
      else $error("full flag fell off a push edge");

   a_axi_bhold : assert property (@(posedge core_clk) disable iff (!rst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");

endmodule : dcbf_fifo

/* rtl/dcbf_pkg.sv */
// Shared constants of the dual clock byte FIFO: widths, depths, map, fields.
// Assumes a single core clock that samples all pin-side clocks and strobes.
package dcbf_pkg;

   // ---------------------------------------------------------------
   // Data and depth
   // ---------------------------------------------------------------
   localparam int WORD_W        = 8;
   localparam int DEPTH_DEF     = 64;
   localparam int ALMOST_OFFSET = 7;

   // ---------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam int             AXI_ADDR_W  = 4;
   localparam logic [3:0]     ADDR_CTRL   = 4'h0;
   localparam logic [3:0]     ADDR_STATUS = 4'h4;
   localparam logic [3:0]     ADDR_DEPTH  = 4'h8;
   localparam int             CTRL_CLEAR_POS   = 0;
   localparam logic           CTRL_CLEAR_RST   = 1'h0;
   localparam int             ST_EMPTY_POS     = 0;
   localparam int             ST_AEMPTY_POS    = 1;
   localparam int             ST_NFULL_POS     = 2;
   localparam int             ST_FULL_POS      = 3;
   localparam int             ST_COUNT_POS     = 16;
   localparam logic [1:0]     RESP_OKAY   = 2'h0;
   localparam logic [1:0]     RESP_SLVERR = 2'h2;

endpackage : dcbf_pkg

/* rtl/dcbf_stream_if.sv */
// Valid/ready word stream from the storage array to the pop buffer and from the pop buffer to the pop port.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface dcbf_stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : dcbf_stream_if

/* rtl/dcbf_pop_buffer.sv */
// Two-entry buffer holding prefetched words ahead of the pop port.
// Assumes a synchronous active-low reset and a synchronous flush.
`timescale 1ns/1ns
module dcbf_pop_buffer #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic   core_clk,
   input wire logic   rst_n,
   input wire logic   flush,
   // Streams
   dcbf_stream_if.snk fill,
   dcbf_stream_if.src drain
);
   logic [1:0]   occ_r;
   logic [W-1:0] head_r;
   logic [W-1:0] tail_r;
   logic         take;
   logic         give;

   assign fill.ready  = (occ_r != 2'h2);
   assign drain.valid = (occ_r != 2'h0);
   assign drain.data  = head_r;
   assign take        = fill.valid && fill.ready;
   assign give        = drain.valid && drain.ready;

   always_ff @(posedge core_clk) begin
      if (!rst_n || flush) begin
         occ_r <= 2'h0;
      end else begin
         occ_r <= occ_r + 2'(take) - 2'(give);
      end
   end

   // Head always holds the oldest word; tail only when two are held
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         head_r <= '0;
         tail_r <= '0;
      end else begin
         if (give) begin
            head_r <= (occ_r == 2'h2) ? tail_r : fill.data;
         end else if (take && occ_r == 2'h0) begin
            head_r <= fill.data;
         end
         if (take && ((occ_r == 2'h1 && !give) || occ_r == 2'h2)) begin
            tail_r <= fill.data;
         end
      end
   end

   a_buf_bound : assert property (@(posedge core_clk) disable iff (!rst_n)
      occ_r <= 2'h2) else $error("pop buffer over two entries");

endmodule : dcbf_pop_buffer

/* verification/dcbf_pin_agent.sv */
// Pin-level writer and reader model standing outside the byte FIFO.
// Assumes pins are sampled by core_clk; one edge per side per call.
`timescale 1ns/1ns
module dcbf_pin_agent (
   // Core clock
   input  wire logic       core_clk,
   // Writer and reader pins
   output logic            pushClk,
   output logic            pushEnN,
   output logic [7:0]      pushWord,
   output logic            popClk,
   output logic            popEnN
);
   initial begin
      pushClk  = 1'b0;
      pushEnN  = 1'b1;
      pushWord = 8'h00;
      popClk   = 1'b0;
      popEnN   = 1'b1;
   end

   // Data and enable held three core cycles on both sides of the rising edge
   task automatic cyc(input bit wr, input bit en, input logic [7:0] d);
      @(posedge core_clk);
      pushEnN  <= wr ? !en : 1'b1;
      popEnN   <= wr ? 1'b1 : !en;
      pushWord <= wr ? d : pushWord;
      repeat (3) @(posedge core_clk);
      pushClk <= wr;
      popClk  <= !wr;
      repeat (3) @(posedge core_clk);
      pushClk  <= 1'b0;
      popClk   <= 1'b0;
      pushEnN  <= 1'b1;
      popEnN   <= 1'b1;
      // Released bus shows the inverse, not a stale copy
      pushWord <= ~d;
      repeat (3) @(posedge core_clk);
   endtask : cyc

   // Both clocks rise together, as when the two are tied
   task automatic tied(input logic [7:0] d);
      @(posedge core_clk);
      pushEnN  <= 1'b0;
      popEnN   <= 1'b0;
      pushWord <= d;
      repeat (3) @(posedge core_clk);
      pushClk <= 1'b1;
      popClk  <= 1'b1;
      repeat (3) @(posedge core_clk);
      pushClk  <= 1'b0;
      popClk   <= 1'b0;
      pushEnN  <= 1'b1;
      popEnN   <= 1'b1;
      pushWord <= ~d;
      repeat (3) @(posedge core_clk);
   endtask : tied
endmodule : dcbf_pin_agent

/* verification/tb_top.sv */
// Self-checking bench for the dual clock byte FIFO.
// Assumes the pin agent model and the AXI4-Lite status map of the package.
`timescale 1ns/1ns
module tb_top;
   import dcbf_pkg::*;
   localparam int DEPTH = 64;
   logic coreClk = 1'b0, rstN = 1'b0, clearN = 1'b1, outEnN = 1'b0;
   logic [3:0] awAddr = 4'h0, arAddr = 4'h0;
   logic [31:0] wData = 32'h0, rdVal;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid, pushClk, pushEnN, popClk, popEnN;
   logic popOe, emptyN, aEmptyN, nFullN, fullN;
   logic [1:0] bResp, rResp, resp;
   logic [31:0] rData;
   logic [7:0] pushWord, popWord, d;
   logic [7:0] model[$];
   int numErrors = 0, cmpCount = 0;

   always #4 coreClk = ~coreClk;

   dcbf_fifo #(.DEPTH(DEPTH)) i_dcbf_fifo (.core_clk(coreClk), .rst_n(rstN),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .push_clk(pushClk), .push_en_n(pushEnN), .push_word(pushWord), .pop_clk(popClk),
      .pop_en_n(popEnN), .out_en_n(outEnN), .pop_word(popWord), .pop_word_oe(popOe),
      .fifo_clear_n(clearN), .empty_flag_n(emptyN), .almost_empty_n(aEmptyN),
      .near_full_n(nFullN), .full_flag_n(fullN));

   dcbf_pin_agent i_dcbf_pin_agent (.core_clk(coreClk), .pushClk(pushClk),
      .pushEnN(pushEnN), .pushWord(pushWord), .popClk(popClk), .popEnN(popEnN));

   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         numErrors++;
      end
   endtask : check

   task automatic giveVerdict();
      if (numErrors == 0 && cmpCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : giveVerdict

   // Flags as {full, near full, almost empty, empty}, all active low
   function automatic logic [31:0] expFlags(input int n);
      expFlags = {28'h0, n < DEPTH, DEPTH - n > 7, n > 7, n > 0};
   endfunction : expFlags

   function automatic logic [31:0] flags();
      flags = {28'h0, fullN, nFullN, aEmptyN, emptyN};
   endfunction : flags

   task automatic axiWr(input logic [3:0] a, input logic [31:0] v);
      @(posedge coreClk);
      awAddr  <= a;
      awValid <= 1'b1;
      wData   <= v;
      wValid  <= 1'b1;
      bReady  <= 1'b1;
      do begin
         @(posedge coreClk);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
      end while (bValid !== 1'b1);
      resp = bResp;
      bReady <= 1'b0;
   endtask : axiWr

   task automatic axiRd(input logic [3:0] a);
      @(posedge coreClk);
      arAddr  <= a;
      arValid <= 1'b1;
      rReady  <= 1'b1;
      do begin
         @(posedge coreClk);
         if (arValid && arReady) arValid <= 1'b0;
      end while (rValid !== 1'b1);
      rdVal = rData;
      resp  = rResp;
      rReady <= 1'b0;
   endtask : axiRd

   // Flags of each side move only on that side's own clock edge
   task automatic ticks();
      i_dcbf_pin_agent.cyc(1'b1, 1'b0, 8'h00);
      i_dcbf_pin_agent.cyc(1'b0, 1'b0, 8'h00);
   endtask : ticks

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (30000) @(posedge coreClk);
      numErrors++;
      giveVerdict();
   end

   initial begin
      void'($urandom(32'hdab15762));
      repeat (20) @(posedge coreClk);
      rstN <= 1'b1;
      repeat (3) @(posedge coreClk);
      check(flags(), expFlags(0));
      axiRd(ADDR_CTRL);
      check(rdVal, 32'h0);
      axiRd(ADDR_DEPTH);
      check(rdVal, DEPTH);
      axiRd(4'hC);
      check(rdVal, 32'h0);
      check(resp, RESP_SLVERR);
      axiWr(4'hC, 32'h1);
      check(resp, RESP_SLVERR);
      clearN <= 1'b0;
      repeat (6) @(posedge coreClk);
      clearN <= 1'b1;
      repeat (4) @(posedge coreClk);
      for (int n = 1; n <= DEPTH; n++) begin
         d = 8'($urandom);
         model.push_back(d);
         i_dcbf_pin_agent.cyc(1'b1, 1'b1, d);
         i_dcbf_pin_agent.cyc(1'b0, 1'b0, 8'h00);
         check(flags(), expFlags(n));
      end
      i_dcbf_pin_agent.cyc(1'b1, 1'b1, 8'h5A);
      axiRd(ADDR_STATUS);
      check(rdVal, (DEPTH << 16) | expFlags(DEPTH));
      for (int n = DEPTH - 1; n >= 0; n--) begin
         i_dcbf_pin_agent.cyc(1'b0, 1'b1, 8'h00);
         check(popWord, model.pop_front());
         i_dcbf_pin_agent.cyc(1'b1, 1'b0, 8'h00);
         check(flags(), expFlags(n));
      end
      i_dcbf_pin_agent.cyc(1'b0, 1'b1, 8'h00);
      check(popWord, d);
      check(flags(), expFlags(0));
      outEnN <= 1'b1;
      repeat (4) @(posedge coreClk);
      check(popOe, 1'b0);
      outEnN <= 1'b0;
      repeat (4) @(posedge coreClk);
      check(popOe, 1'b1);
      for (int k = 0; k < 3; k++) begin
         d = 8'($urandom);
         model.push_back(d);
         i_dcbf_pin_agent.cyc(1'b1, 1'b1, d);
      end
      i_dcbf_pin_agent.cyc(1'b0, 1'b0, 8'h00);
      for (int k = 0; k < 8; k++) begin
         d = 8'($urandom);
         model.push_back(d);
         i_dcbf_pin_agent.tied(d);
         check(popWord, model.pop_front());
         check(flags(), expFlags(3));
      end
      axiWr(ADDR_CTRL, 32'h1);
      check(resp, RESP_OKAY);
      axiWr(ADDR_CTRL, 32'h0);
      ticks();
      check(popWord, 8'h00);
      check(flags(), expFlags(0));
      giveVerdict();
   end
endmodule : tb_top
